// [core/ftt_pkg.sv]
package ftt_pkg;
    // widths
    localparam int unsigned CNT_W = 10;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned HI_W = 2;
    localparam int unsigned PRESC_W = 14; // deepest tap gives divide by 16384
    localparam int unsigned CS_W = 4;
    localparam int unsigned WGM_W = 2;
    localparam int unsigned NCH = 3; // compare channels a, b, d
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // compare channel slots
    localparam int unsigned CH_A = 0;
    localparam int unsigned CH_B = 1;
    localparam int unsigned CH_D = 2;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL_C = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CTRL_D = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CTRL_E = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_HIGH_BUF = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CMP_TOP = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_CMP_D = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_PLL_CS = 8'h34;
    // field positions
    localparam int unsigned BIT_PWM_A = 0;
    localparam int unsigned BIT_PWM_B = 1;
    localparam int unsigned CS_LSB = 0;
    localparam int unsigned BIT_PSR = 6;
    localparam int unsigned WGM_LSB = 0;
    localparam int unsigned BIT_FAULT_FLAG = 2;
    localparam int unsigned BIT_FAULT_IE = 7;
    localparam int unsigned BIT_OVF = 2;
    localparam int unsigned BIT_CF_B = 5;
    localparam int unsigned BIT_CF_A = 6;
    localparam int unsigned BIT_CF_D = 7;
    localparam int unsigned BIT_PLL_LOCK = 0;
    localparam int unsigned BIT_FAST_EN = 2;
    localparam int unsigned BIT_LOW_SPEED = 7;
    // values
    localparam logic [CS_W-1:0] CS_STOP = 4'h0;
    localparam logic [CS_W-1:0] CS_DIV1 = 4'h1;
    localparam logic [CNT_W-1:0] BOTTOM_VAL = 10'h000;
    localparam logic [CNT_W-1:0] MAX_VAL = 10'h0FF;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        WGM_NORMAL = 2'b00,
        WGM_UPDOWN = 2'b01,
        WGM_ALT = 2'b10,
        WGM_MAX_TOP = 2'b11
    } ftt_wgm_t;

    typedef enum logic
    {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } ftt_dir_t;

    // settings as seen by the counting logic, after the input crossing
    typedef struct packed {
        logic [CS_W-1:0] clkSel;
        ftt_wgm_t wgm;
        logic pwmA;
        logic pwmB;
        logic fastEn;
        logic lowSpeed;
        logic [NCH-1:0][CNT_W-1:0] cmp;
        logic [CNT_W-1:0] top;
    } ftt_cfg_t;
endpackage

// [core/ftt_prescaler.sv]
`timescale 1ns/100ps
module ftt_prescaler #(
    parameter int unsigned DIV_W = ftt_pkg::PRESC_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic srcTick,
    input wire logic prescReset,
    input wire logic [ftt_pkg::CS_W-1:0] clockSelectField,
    output logic timerClockEnable
);
    typedef struct packed {
        logic [DIV_W-1:0] div;
    } ftt_presc_state_t;

    ftt_presc_state_t s_r;
    ftt_presc_state_t s_nxt;
    logic [DIV_W:0] span;
    logic [DIV_W-1:0] lowMask;
    logic running;

    // a strobe, not a gated clock: fires when the low taps are all ones
    always_comb
    begin
        span = (DIV_W+1)'(1) << (clockSelectField - ftt_pkg::CS_DIV1);
        lowMask = DIV_W'(span - (DIV_W+1)'(1));
        running = clockSelectField != ftt_pkg::CS_STOP;
        timerClockEnable = running & srcTick & ((s_r.div & lowMask) == lowMask);
        s_nxt = s_r;
        if (prescReset)
        begin
            s_nxt.div = '0;
        end
        else if (running & srcTick)
        begin
            s_nxt.div = s_r.div + DIV_W'(1);
        end
    end

    // divider state, frozen while the clock enable is low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else if (clkEn)
            s_r <= s_nxt;
    end
endmodule // ftt_prescaler

// [core/ftt_core.sv]
// Functional notes
// - fast clock up to 64 MHz; low-speed select halves it to 32 MHz.
// - ten-bit counter and compares; upper bits zero gives eight-bit behaviour.
// - reading a ten-bit low byte copies its upper bits into the high buffer.
// - writing a ten-bit low byte takes its upper bits from the high buffer.
// - top compare holds TOP; counter clears when count matches it, but reverses instead in up-down mode.
// - compares a, b, d drive their own pins and raise match flags.
// - overflow and match flags in flag register, fault in control d, own masks.
// - async mode runs prescaler and counter off the fast clock behind a crossing.
// - written settings pass input synchronising stages before reaching the counter.
// - control and compare registers read back the new value at once.
// - count, high buffer and flags read back after the synchronising delay.
// - BOTTOM is 0x00, MAX is 0xFF, TOP is MAX or compare, by mode.
// - system clock normally; fast-clock enable selects the fast clock.
// - prescaler offers undivided up to divide by 16384, plus stop.
// - writing one to prescaler reset bit clears the prescaler.
// - on each timer clock enable the counter clears, counts up or down.
// - clock select zero produces no timer clock; counter stops.
// - count readable and writable anytime; a write beats clear or count.
// - top indication at sequence maximum, bottom indication at zero.
// - waveform bits and pwm enables pick sequence and overflow point.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
module ftt_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ftt_pkg::ADDR_W-1:0] paddr,
    input wire logic [ftt_pkg::DATA_W-1:0] pwdata,
    output logic [ftt_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fastClkTick,
    input wire logic pllLocked,
    input wire logic faultIn,
    output logic compareOutPinA,
    output logic compareOutPinB,
    output logic compareOutPinD,
    output logic timerClockEnable,
    output logic atTop,
    output logic atBottom,
    output logic atMax
);
    localparam int unsigned CW = ftt_pkg::CNT_W;
    localparam int unsigned HW = ftt_pkg::HI_W;
    localparam int unsigned BW = ftt_pkg::BYTE_W;
    localparam int unsigned NCH = ftt_pkg::NCH;
    localparam int unsigned OBS_W = CW + HW + 1 + NCH;

    typedef struct packed {
        logic [BW-1:0] ctrlA;
        logic [BW-1:0] ctrlB;
        logic [BW-1:0] ctrlC;
        logic [BW-1:0] ctrlD;
        logic [BW-1:0] ctrlE;
        logic [BW-1:0] irqMask;
        logic fastEn;
        logic lowSpeed;
        logic [NCH-1:0][CW-1:0] cmpCpu;
        logic [CW-1:0] topCpu;
        logic [HW-1:0] highBuf;
        ftt_pkg::ftt_cfg_t cfgS1;
        ftt_pkg::ftt_cfg_t cfgS2;
        logic cntWrS1;
        logic cntWrS2;
        logic [CW-1:0] cntValS1;
        logic [CW-1:0] cntValS2;
        logic psrS1;
        logic psrS2;
        logic [CW-1:0] count;
        ftt_pkg::ftt_dir_t dir;
        logic halfPhase;
        logic blockMatch;
        logic ovf;
        logic fault;
        logic [NCH-1:0] cmpFlag;
        logic [NCH-1:0] pin;
        logic [OBS_W-1:0] obsS1;
        logic [OBS_W-1:0] obsS2;
        logic [ftt_pkg::DATA_W-1:0] prdata;
        logic [HW-1:0] rdHi;
        logic rdTen;
    } ftt_core_state_t;

    ftt_core_state_t s_r, s_nxt;
    ftt_pkg::ftt_cfg_t cpuCfg, cfg;
    logic [BW-1:0] wrByte, rdByte, flagByte, ctrlDByte, pllByte;
    logic [HW-1:0] rdHigh, obsHi;
    logic [CW-1:0] obsCnt, topVal, cntNext;
    logic [NCH-1:0] obsCf, chPwm, flagClr;
    logic rdTen, hit, obsOvf, upDown, srcTick, tick, setupPhase, accessPhase, ovfClr, faultClr;

    // settings as software left them, before the crossing
    always_comb
    begin
        cpuCfg.clkSel = s_r.ctrlB[ftt_pkg::CS_LSB +: ftt_pkg::CS_W];
        cpuCfg.wgm = ftt_pkg::ftt_wgm_t'(s_r.ctrlD[ftt_pkg::WGM_LSB +: ftt_pkg::WGM_W]);
        cpuCfg.pwmA = s_r.ctrlA[ftt_pkg::BIT_PWM_A];
        cpuCfg.pwmB = s_r.ctrlA[ftt_pkg::BIT_PWM_B];
        cpuCfg.fastEn = s_r.fastEn;
        cpuCfg.lowSpeed = s_r.lowSpeed;
        cpuCfg.cmp = s_r.cmpCpu;
        cpuCfg.top = s_r.topCpu;
    end

    // the counter only ever sees the second synchronising stage
    assign cfg = s_r.cfgS2;

    // delayed view of the counting side for software reads
    assign obsCnt = s_r.obsS2[OBS_W-1 -: CW];
    assign obsHi = s_r.obsS2[NCH+1 +: HW];
    assign obsOvf = s_r.obsS2[NCH];
    assign obsCf = s_r.obsS2[NCH-1:0];

    // assembled read bytes for the flag, control d and pll registers
    always_comb
    begin
        flagByte = ftt_pkg::BYTE_ZERO;
        flagByte[ftt_pkg::BIT_OVF] = obsOvf;
        flagByte[ftt_pkg::BIT_CF_A] = obsCf[ftt_pkg::CH_A];
        flagByte[ftt_pkg::BIT_CF_B] = obsCf[ftt_pkg::CH_B];
        flagByte[ftt_pkg::BIT_CF_D] = obsCf[ftt_pkg::CH_D];
        ctrlDByte = s_r.ctrlD;
        ctrlDByte[ftt_pkg::BIT_FAULT_FLAG] = s_r.fault;
        pllByte = ftt_pkg::BYTE_ZERO;
        pllByte[ftt_pkg::BIT_PLL_LOCK] = pllLocked;
        pllByte[ftt_pkg::BIT_FAST_EN] = s_r.fastEn;
        pllByte[ftt_pkg::BIT_LOW_SPEED] = s_r.lowSpeed;
    end

    // address decode; ten-bit registers also report their upper bits
    always_comb
    begin
        rdByte = ftt_pkg::BYTE_ZERO;
        rdHigh = '0;
        rdTen = 1'b0;
        hit = 1'b1;
        case (paddr)
            ftt_pkg::OFS_CTRL_A: rdByte = s_r.ctrlA;
            ftt_pkg::OFS_CTRL_B: rdByte = s_r.ctrlB;
            ftt_pkg::OFS_CTRL_C: rdByte = s_r.ctrlC;
            ftt_pkg::OFS_CTRL_D: rdByte = ctrlDByte;
            ftt_pkg::OFS_CTRL_E: rdByte = s_r.ctrlE;
            ftt_pkg::OFS_COUNT: {rdTen, rdHigh, rdByte} = {1'b1, obsCnt};
            ftt_pkg::OFS_HIGH_BUF: rdByte = BW'(obsHi);
            ftt_pkg::OFS_CMP_A: {rdTen, rdHigh, rdByte} = {1'b1, s_r.cmpCpu[ftt_pkg::CH_A]};
            ftt_pkg::OFS_CMP_B: {rdTen, rdHigh, rdByte} = {1'b1, s_r.cmpCpu[ftt_pkg::CH_B]};
            ftt_pkg::OFS_CMP_TOP: {rdTen, rdHigh, rdByte} = {1'b1, s_r.topCpu};
            ftt_pkg::OFS_CMP_D: {rdTen, rdHigh, rdByte} = {1'b1, s_r.cmpCpu[ftt_pkg::CH_D]};
            ftt_pkg::OFS_IRQ_FLAG: rdByte = flagByte;
            ftt_pkg::OFS_IRQ_MASK: rdByte = s_r.irqMask;
            ftt_pkg::OFS_PLL_CS: rdByte = pllByte;
            default: hit = 1'b0;
        endcase
    end

    // zero wait states; a low clock enable stretches the access phase
    assign pready = clkEn;
    assign pslverr = psel & penable & ~hit;
    assign prdata = s_r.prdata;
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign wrByte = pwdata[BW-1:0];

    // source tick: every system cycle, or fast ticks, halved in low speed
    assign srcTick = ~cfg.fastEn | (fastClkTick & (~cfg.lowSpeed | s_r.halfPhase));

    ftt_prescaler #(
        .DIV_W(ftt_pkg::PRESC_W)
    ) u_presc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .srcTick(srcTick),
        .prescReset(s_r.psrS2),
        .clockSelectField(cfg.clkSel),
        .timerClockEnable(tick)
    );

    assign timerClockEnable = tick;

    // sequence selection from the synchronised mode bits
    always_comb
    begin
        upDown = (cfg.pwmA | cfg.pwmB) & (cfg.wgm == ftt_pkg::WGM_UPDOWN);
        if (~(cfg.pwmA | cfg.pwmB) & (cfg.wgm == ftt_pkg::WGM_MAX_TOP))
            topVal = ftt_pkg::MAX_VAL;
        else
            topVal = cfg.top;
        chPwm[ftt_pkg::CH_A] = cfg.pwmA;
        chPwm[ftt_pkg::CH_B] = cfg.pwmB;
        chPwm[ftt_pkg::CH_D] = cfg.pwmA;
    end

    // status indications straight off the count register
    assign atTop = s_r.count == topVal;
    assign atBottom = s_r.count == ftt_pkg::BOTTOM_VAL;
    assign atMax = s_r.count == ftt_pkg::MAX_VAL;
    assign compareOutPinA = s_r.pin[ftt_pkg::CH_A];
    assign compareOutPinB = s_r.pin[ftt_pkg::CH_B];
    assign compareOutPinD = s_r.pin[ftt_pkg::CH_D];

    // next state: bus side first, then the counting side
    always_comb
    begin
        s_nxt = s_r;
        flagClr = '0;
        ovfClr = 1'b0;
        faultClr = 1'b0;
        cntNext = s_r.count;
        s_nxt.cfgS1 = cpuCfg;
        s_nxt.cfgS2 = s_r.cfgS1;
        s_nxt.cntWrS1 = 1'b0;
        s_nxt.cntWrS2 = s_r.cntWrS1;
        s_nxt.cntValS2 = s_r.cntValS1;
        s_nxt.psrS1 = 1'b0;
        s_nxt.psrS2 = s_r.psrS1;
        s_nxt.obsS1 = {s_r.count, s_r.highBuf, s_r.ovf, s_r.cmpFlag};
        s_nxt.obsS2 = s_r.obsS1;
        // read data is captured in setup so it is stable through access
        if (setupPhase)
        begin
            s_nxt.prdata = ftt_pkg::RD_ZERO | ftt_pkg::DATA_W'(rdByte);
            s_nxt.rdHi = rdHigh;
            s_nxt.rdTen = rdTen & ~pwrite;
        end
        if (accessPhase & ~pwrite & s_r.rdTen)
        begin
            s_nxt.highBuf = s_r.rdHi;
        end
        if (accessPhase & pwrite & hit)
        begin
            case (paddr)
                ftt_pkg::OFS_CTRL_A: s_nxt.ctrlA = wrByte;
                ftt_pkg::OFS_CTRL_B:
                begin
                    s_nxt.ctrlB = wrByte;
                    s_nxt.ctrlB[ftt_pkg::BIT_PSR] = 1'b0; // strobe bit, never stored
                    s_nxt.psrS1 = wrByte[ftt_pkg::BIT_PSR];
                end
                ftt_pkg::OFS_CTRL_C: s_nxt.ctrlC = wrByte;
                ftt_pkg::OFS_CTRL_D:
                begin
                    s_nxt.ctrlD = wrByte;
                    s_nxt.ctrlD[ftt_pkg::BIT_FAULT_FLAG] = 1'b0;
                    faultClr = wrByte[ftt_pkg::BIT_FAULT_FLAG];
                end
                ftt_pkg::OFS_CTRL_E: s_nxt.ctrlE = wrByte;
                ftt_pkg::OFS_COUNT:
                begin
                    s_nxt.cntWrS1 = 1'b1;
                    s_nxt.cntValS1 = {s_r.highBuf, wrByte};
                end
                ftt_pkg::OFS_HIGH_BUF: s_nxt.highBuf = wrByte[HW-1:0];
                ftt_pkg::OFS_CMP_A: s_nxt.cmpCpu[ftt_pkg::CH_A] = {s_r.highBuf, wrByte};
                ftt_pkg::OFS_CMP_B: s_nxt.cmpCpu[ftt_pkg::CH_B] = {s_r.highBuf, wrByte};
                ftt_pkg::OFS_CMP_TOP: s_nxt.topCpu = {s_r.highBuf, wrByte};
                ftt_pkg::OFS_CMP_D: s_nxt.cmpCpu[ftt_pkg::CH_D] = {s_r.highBuf, wrByte};
                ftt_pkg::OFS_IRQ_FLAG:
                begin
                    // write one to clear
                    ovfClr = wrByte[ftt_pkg::BIT_OVF];
                    flagClr[ftt_pkg::CH_A] = wrByte[ftt_pkg::BIT_CF_A];
                    flagClr[ftt_pkg::CH_B] = wrByte[ftt_pkg::BIT_CF_B];
                    flagClr[ftt_pkg::CH_D] = wrByte[ftt_pkg::BIT_CF_D];
                end
                ftt_pkg::OFS_IRQ_MASK: s_nxt.irqMask = wrByte;
                ftt_pkg::OFS_PLL_CS:
                begin
                    s_nxt.fastEn = wrByte[ftt_pkg::BIT_FAST_EN];
                    s_nxt.lowSpeed = wrByte[ftt_pkg::BIT_LOW_SPEED];
                end
                default: s_nxt.ctrlA = s_r.ctrlA;
            endcase
        end
        // low-speed halving of the fast tick stream
        if (cfg.fastEn & cfg.lowSpeed)
            s_nxt.halfPhase = s_r.halfPhase ^ fastClkTick;
        else
            s_nxt.halfPhase = 1'b0;
        // clears are applied before sets so a same-cycle event survives
        s_nxt.ovf = s_r.ovf & ~ovfClr;
        s_nxt.cmpFlag = s_r.cmpFlag & ~flagClr;
        s_nxt.fault = (s_r.fault & ~faultClr) | faultIn;
        if (tick)
        begin
            s_nxt.blockMatch = 1'b0;
            case (upDown)
                1'b1:
                begin
                    case (s_r.dir)
                        ftt_pkg::DIR_DOWN:
                        begin
                            if (s_r.count == ftt_pkg::BOTTOM_VAL)
                            begin
                                s_nxt.dir = ftt_pkg::DIR_UP;
                                cntNext = s_r.count + ftt_pkg::CNT_ONE;
                                s_nxt.ovf = 1'b1;
                            end
                            else
                                cntNext = s_r.count - ftt_pkg::CNT_ONE;
                        end
                        default:
                        begin
                            if (s_r.count >= topVal)
                            begin
                                s_nxt.dir = ftt_pkg::DIR_DOWN;
                                cntNext = s_r.count - ftt_pkg::CNT_ONE;
                            end
                            else
                                cntNext = s_r.count + ftt_pkg::CNT_ONE;
                        end
                    endcase
                end
                default:
                begin
                    s_nxt.dir = ftt_pkg::DIR_UP;
                    // >= so a top moved below the count still wraps
                    if (s_r.count >= topVal)
                    begin
                        cntNext = ftt_pkg::BOTTOM_VAL;
                        s_nxt.ovf = 1'b1;
                    end
                    else
                        cntNext = s_r.count + ftt_pkg::CNT_ONE;
                end
            endcase
            s_nxt.count = cntNext;
            // per channel: full ten-bit compare, so zero upper bits act as eight-bit
            for (int ch = 0; ch < NCH; ch++)
            begin
                if (~s_r.blockMatch & (s_r.count == cfg.cmp[ch]))
                begin
                    s_nxt.cmpFlag[ch] = 1'b1;
                    if (~chPwm[ch])
                        s_nxt.pin[ch] = ~s_r.pin[ch];
                end
                if (chPwm[ch])
                    s_nxt.pin[ch] = cntNext < cfg.cmp[ch];
            end
        end
        // a software count write overrides the count that the tick decided; its flag and pin updates stand
        if (s_r.cntWrS2)
        begin
            s_nxt.count = s_r.cntValS2;
            s_nxt.blockMatch = 1'b1;
        end
    end

    // every reset value is zero, so the whole struct clears at once
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else if (clkEn)
            s_r <= s_nxt;
    end
endmodule // ftt_core

// [bench/ftt_core_checker.sv]
`timescale 1ns/100ps
module ftt_core_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ftt_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic timerClockEnable,
    input wire logic atTop,
    input wire logic atBottom,
    input wire logic atMax,
    input wire logic compareOutPinA
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [1:0] wrAge_r;
    logic quiet;
    // a count write lands two edges late, so count steps are judged only once it has landed
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            wrAge_r <= 2'h0;
        else if (psel && penable && pwrite && pready)
            wrAge_r <= 2'h0;
        else if (wrAge_r != 2'h2)
            wrAge_r <= wrAge_r + 2'h1;
    assign quiet = (wrAge_r == 2'h2);

    property p_ready; pready == clkEn; endproperty
    a_ready: assert property (p_ready) else $error("pready not equal to clkEn");
    property p_errPhase; pslverr |-> psel && penable; endproperty
    a_errPhase: assert property (p_errPhase) else $error("pslverr outside access");
    property p_errZero; psel && penable && pslverr |-> prdata == ftt_pkg::RD_ZERO; endproperty
    a_errZero: assert property (p_errZero) else $error("unmapped read not zero");
    property p_rdHold; psel && penable && pready |=> $stable(prdata); endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data moved early");
    property p_rstState; $rose(rst_n) |-> atBottom && atTop && !atMax; endproperty
    a_rstState: assert property (p_rstState) else $error("bad flags after reset");
    property p_botLeave;
        atBottom && !atTop && timerClockEnable && clkEn && quiet |=> !atBottom;
    endproperty
    a_botLeave: assert property (p_botLeave) else $error("count stuck at bottom");
    property p_maxLeave; atMax && timerClockEnable && clkEn && quiet |=> !atMax; endproperty
    a_maxLeave: assert property (p_maxLeave) else $error("count stuck at max");
    property p_hold; quiet && !timerClockEnable |=> $stable(atBottom) && $stable(atMax); endproperty
    a_hold: assert property (p_hold) else $error("count moved without tick");
    property p_freeze; !clkEn |=> $stable(prdata) && $stable(compareOutPinA); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    c_wrap: cover property (atTop && timerClockEnable);
    c_max: cover property (atMax && timerClockEnable);
    c_err: cover property (pslverr);
endmodule // ftt_core_checker

bind ftt_core ftt_core_checker u_chk (.clk_sys, .rst_n, .clkEn, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .timerClockEnable, .atTop, .atBottom, .atMax, .compareOutPinA);

// [bench/fast_ten_bit_timer_core_test.sv]
`timescale 1ns/100ps
module fast_ten_bit_timer_core_test;
    logic clk_sys = 1'b0, rst_n = 1'b0, clkEn = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, fastClkTick = 1'b0, pllLocked = 1'b1, faultIn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, compareOutPinA, compareOutPinB, compareOutPinD;
    logic timerClockEnable, atTop, atBottom, atMax, e;
    logic [1:0] fastCnt = 2'h0;
    int failures = 0, n_tests = 0, n;
    localparam logic [7:0] REGS [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h20, 8'h24, 8'h28};

    ftt_core dut (.clk_sys, .rst_n, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fastClkTick, .pllLocked, .faultIn, .compareOutPinA, .compareOutPinB,
        .compareOutPinD, .timerClockEnable, .atTop, .atBottom, .atMax);

    always #2 clk_sys = ~clk_sys;
    // fast clock stands in as one tick every fourth system cycle, already synchronised
    always @(posedge clk_sys)
    begin
        fastCnt <= fastCnt + 2'h1;
        fastClkTick <= (fastCnt == 2'h3);
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, entered right after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        if (i >= 50)
        begin
            failures++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask

    // ten-bit write: upper bits go to the shared buffer first, then the low byte
    task automatic wr10(input logic [7:0] a, input logic [9:0] v);
        apb(1'b1, ftt_pkg::OFS_HIGH_BUF, {30'h0, v[9:8]});
        apb(1'b1, a, {24'h0, v[7:0]});
    endtask

    function automatic logic pick(int w);
        case (w)
            0: return atBottom;
            1: return atTop;
            2: return atMax;
            default: return timerClockEnable;
        endcase
    endfunction

    // cycles from one port event to the next of another, once new settings have crossed
    task automatic span(input int a, input int b, input int exp);
        int i;
        i = 0;
        repeat (2) @(negedge clk_sys);
        while (pick(a) !== 1'b1 && i < 20000)
        begin
            @(negedge clk_sys);
            i++;
        end
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (pick(b) !== 1'b1 && n < 20000);
        if (n >= 20000 || i >= 20000)
        begin
            failures++;
            end_of_test();
        end
        check(n, exp);
        @(posedge clk_sys);
    endtask

    task automatic t_basic();
        check({29'h0, atTop, atBottom, atMax}, 32'h0000_0006);
        rdc(ftt_pkg::OFS_IRQ_FLAG, 32'h0000_0000);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, REGS[k], 32'h0000_0003);
            rdc(REGS[k], 32'h0000_0003);
        end
        apb(1'b1, 8'hFC, 32'h0000_00FF);
        check({31'h0, e}, 32'h0000_0001);
        rdc(8'hFC, 32'h0000_0000);
    endtask

    task automatic t_ten_bit();
        wr10(ftt_pkg::OFS_CMP_B, 10'h2C7);
        apb(1'b1, ftt_pkg::OFS_HIGH_BUF, 32'h0000_0000);
        rdc(ftt_pkg::OFS_CMP_B, 32'h0000_00C7);
        repeat (2) @(posedge clk_sys);
        rdc(ftt_pkg::OFS_HIGH_BUF, 32'h0000_0002);
        apb(1'b1, ftt_pkg::OFS_CTRL_B, 32'h0000_0000);
        wr10(ftt_pkg::OFS_COUNT, 10'h123);
        repeat (20) @(posedge clk_sys);
        rdc(ftt_pkg::OFS_COUNT, 32'h0000_0023);
        repeat (2) @(posedge clk_sys);
        rdc(ftt_pkg::OFS_HIGH_BUF, 32'h0000_0001);
    endtask

    task automatic t_modes();
        wr10(ftt_pkg::OFS_CMP_TOP, 10'h004);
        apb(1'b1, ftt_pkg::OFS_CTRL_A, 32'h0000_0000);
        apb(1'b1, ftt_pkg::OFS_CTRL_D, 32'h0000_0000);
        wr10(ftt_pkg::OFS_COUNT, 10'h000);
        apb(1'b1, ftt_pkg::OFS_IRQ_FLAG, 32'h0000_00FF);
        apb(1'b1, ftt_pkg::OFS_CTRL_B, 32'h0000_0001);
        span(0, 1, 4);
        span(1, 0, 1);
        apb(1'b0, ftt_pkg::OFS_IRQ_FLAG, 32'h0000_0000);
        check(q, 32'h0000_00C4);
        apb(1'b1, ftt_pkg::OFS_CTRL_A, 32'h0000_0001);
        apb(1'b1, ftt_pkg::OFS_CTRL_D, 32'h0000_0001);
        span(1, 0, 4);
        span(0, 1, 4);
        apb(1'b1, ftt_pkg::OFS_CTRL_A, 32'h0000_0000);
        apb(1'b1, ftt_pkg::OFS_CTRL_D, 32'h0000_0003);
        span(2, 0, 1);
        span(0, 2, 255);
    endtask

    task automatic t_clocks();
        int cs [4] = '{1, 2, 3, 15};
        foreach (cs[k])
        begin
            apb(1'b1, ftt_pkg::OFS_CTRL_B, 32'(cs[k]));
            span(3, 3, 1 << (cs[k] - 1));
        end
        rdc(ftt_pkg::OFS_PLL_CS, 32'h0000_0001);
        apb(1'b1, ftt_pkg::OFS_PLL_CS, 32'h0000_0004);
        apb(1'b1, ftt_pkg::OFS_CTRL_B, 32'h0000_0001);
        span(3, 3, 4);
        apb(1'b1, ftt_pkg::OFS_PLL_CS, 32'h0000_0084);
        span(3, 3, 8);
    endtask

    task automatic t_fault();
        faultIn <= 1'b1;
        clkEn <= 1'b0;
        @(negedge clk_sys);
        check({31'h0, pready}, 32'h0000_0000);
        @(posedge clk_sys);
        clkEn <= 1'b1;
        @(posedge clk_sys);
        faultIn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, ftt_pkg::OFS_CTRL_D, 32'h0000_0000);
        check(q, 32'h0000_0007);
        apb(1'b1, ftt_pkg::OFS_IRQ_MASK, 32'h0000_00E4);
        rdc(ftt_pkg::OFS_IRQ_MASK, 32'h0000_00E4);
    endtask

    // reset held two cycles, first transfer two cycles after release
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_basic();
        t_ten_bit();
        t_modes();
        t_clocks();
        t_fault();
        end_of_test();
    end
endmodule // fast_ten_bit_timer_core_test
